// ==== hdl/ifp_pkg.sv ====
/*
  constants of the interrupt flag and priority unit: register addresses,
  reset values, source bit positions and edge polarity masks.
  assumes one 16-bit source vector: first flags in bits 7:0, second in 15:8.
*/
package ifp_pkg;
  localparam int SRC_W = 16; // both flag registers side by side
  localparam int REG_W = 8; // width of one flag register
  localparam int IDX_W = 4; // width of a vector index
  // register addresses on the internal data bus
  localparam logic [15:0] SECOND_FLAGS_ADDR = 16'h0008;
  localparam logic [15:0] FIRST_FLAGS_ADDR = 16'h002c;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'h00; // read data of an unmapped address
  localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
  // base of each register inside the source vector
  localparam int FIRST_BASE = 0;
  localparam int SECOND_BASE = 8;
  // first register sources
  localparam int B_P4_PIN4_RISE = 0;
  localparam int B_P4_PIN5_RISE = 1;
  localparam int B_P4_PIN6_FALL = 2;
  localparam int B_P4_PIN7_FALL = 3;
  localparam int B_P5_PIN0_RISE = 4;
  localparam int B_P5_PIN1_RISE = 5;
  localparam int B_P5_PIN2_FALL = 6;
  localparam int B_P5_PIN3_FALL = 7;
  // second register sources (bits 9:8 carry nothing here)
  localparam int B_P5_PIN6_RISE = 10;
  localparam int B_P5_PIN7_FALL = 11;
  localparam int B_TIMER1 = 12;
  localparam int B_TIMER2 = 13;
  localparam int B_EXT_FIRST = 14;
  localparam int B_EXT_SECOND = 15;
  // polarity masks, one bit per source position
  localparam logic [SRC_W-1:0] RISE_MASK = 16'h3433;
  localparam logic [SRC_W-1:0] FALL_MASK = 16'hc8cc;
  localparam logic [SRC_W-1:0] LEVEL_MASK = 16'hc000;
  // previous-sample reset: idle high for falling sources, low for rising
  localparam logic [SRC_W-1:0] PREV_RESET = FALL_MASK;
  localparam logic [SRC_W-1:0] SRC_ZERO = 16'h0000;
endpackage

// ==== hdl/ifp_evt_if.sv ====
/*
  carrier between the flag unit and its edge capture: raw source levels
  one way, one-cycle event pulses back. assumes a single clock domain.
*/
`timescale 1ns/1ps
interface ifp_evt_if;
  import ifp_pkg::*;
  logic [SRC_W-1:0] raw; // source levels, bit positions as the flags
  logic [SRC_W-1:0] evt; // one-cycle pulse per detected edge
  modport det (input raw, output evt);
  modport top (output raw, input evt);
endinterface

// ==== hdl/ifp_edge_capture.sv ====
/*
  edge capture for all flag sources: one previous-sample register per bit
  and a polarity-masked compare. assumes raw levels synchronous to clk.
*/
`timescale 1ns/1ps
module ifp_edge_capture
  import ifp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sources in, events out
  ifp_evt_if.det ev
);
  logic [SRC_W-1:0] prev; // level seen on the previous edge
  logic [SRC_W-1:0] next_prev;

  // next sample is simply the present level
  always_comb begin
    next_prev = ev.raw;
  end

  // reset to idle levels so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev <= PREV_RESET;
    end else begin
      prev <= next_prev;
    end
  end

  // per-bit detect; a pulse lasting one sample is still caught
  genvar i;
  generate
    for (i = 0; i < SRC_W; i++) begin : g_bit
      assign ev.evt[i] = (RISE_MASK[i] & ev.raw[i] & ~prev[i])
                       | (FALL_MASK[i] & ~ev.raw[i] & prev[i]);
      // no event without a matching transition
      steady_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        (nrst && ev.raw[i] == prev[i]) |-> !ev.evt[i])
        else $error("event on a steady level");
      // falling transition reported for falling sources only
      fall_seen_a: assert property (@(posedge clk) disable iff (!nrst)
        (nrst && $past(nrst) && $fell(ev.raw[i])) |-> (ev.evt[i] == FALL_MASK[i]))
        else $error("falling edge handled wrongly");
    end
  endgenerate
endmodule

// ==== hdl/ifp_flag_unit.sv ====
/*
  interrupt flag registers and vector priority for a small controller.
  holds both flag registers, decodes their two bus addresses, merges edge
  events and held low requests into the flags and picks the winning index.
  assumes a synchronous internal data bus (address, read, write strobes)
  and enable bits supplied from the enable registers outside this block.
  assumes every source pin is already synchronous to clk: an edge is seen
  by sampling, so a pulse shorter than one clock period can be missed.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - a source event sets its flag bit
// - low request sets flag, holds while low
// - edge flags set only on configured transition
// - edges are caught during bus accesses too
// - reads return flags without changing them
// - writing one clears once, may set again
// - writing zero leaves a bit alone
// - highest set and enabled bit wins
// - second register ranks above the first
// - first bits 7,6,3,2: pin falling edges
// - first bits 5,4,1,0: pin rising edges
// - second bits 7,6: external low requests
// - second bits 5,4: timer two, timer one
// - second bit 3 falling, bit 2 rising
module ifp_flag_unit
  import ifp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // internal data bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // enable bits from the enable registers
  input wire logic [7:0] enable_first,
  input wire logic [7:0] enable_second,
  // port pin sources
  input wire logic port4_pin4,
  input wire logic port4_pin5,
  input wire logic port4_pin6,
  input wire logic port4_pin7,
  input wire logic port5_pin0,
  input wire logic port5_pin1,
  input wire logic port5_pin2,
  input wire logic port5_pin3,
  input wire logic port5_pin6,
  input wire logic port5_pin7,
  // timer edge events
  input wire logic timer1_edge,
  input wire logic timer2_edge,
  // external low-level requests
  input wire logic first_external_low_request_n,
  input wire logic second_external_low_request_n,
  // toward the processor core
  output logic irq_request,
  output logic [3:0] vector_index
);
  ifp_evt_if ev (); // raw levels out, edge pulses back

  logic [SRC_W-1:0] flags; // {second, first}
  logic [SRC_W-1:0] next_flags;
  logic [SRC_W-1:0] set_vec; // bits set this cycle
  logic [SRC_W-1:0] clr_vec; // bits cleared by a write this cycle
  logic [SRC_W-1:0] hold_vec; // level sources still held low
  logic [SRC_W-1:0] enables;
  logic [SRC_W-1:0] pending; // set and enabled
  logic [7:0] next_rdata;
  logic next_irq;
  logic [IDX_W-1:0] next_index;
  logic [SRC_W-1:0] pend_q; // pending as seen by the last vector choice
  logic hit_first;
  logic hit_second;

  // source wiring into the flag bit positions
  // spare positions stay tied low, so they can never raise a flag
  always_comb begin
    ev.raw = SRC_ZERO;
    ev.raw[B_P5_PIN3_FALL] = port5_pin3;
    ev.raw[B_P5_PIN2_FALL] = port5_pin2;
    ev.raw[B_P4_PIN7_FALL] = port4_pin7;
    ev.raw[B_P4_PIN6_FALL] = port4_pin6;
    ev.raw[B_P5_PIN1_RISE] = port5_pin1;
    ev.raw[B_P5_PIN0_RISE] = port5_pin0;
    ev.raw[B_P4_PIN5_RISE] = port4_pin5;
    ev.raw[B_P4_PIN4_RISE] = port4_pin4;
    ev.raw[B_EXT_SECOND] = second_external_low_request_n;
    ev.raw[B_EXT_FIRST] = first_external_low_request_n;
    ev.raw[B_TIMER2] = timer2_edge;
    ev.raw[B_TIMER1] = timer1_edge;
    ev.raw[B_P5_PIN7_FALL] = port5_pin7;
    ev.raw[B_P5_PIN6_RISE] = port5_pin6;
  end

  // shared edge detector for every source
  ifp_edge_capture u_edges (
    .clk(clk),
    .nrst(nrst),
    .ev(ev)
  );

  // address decode for the write-one-to-clear path
  // both decodes stay live, so a read and a write in one cycle both act
  assign hit_first = (bus_addr == FIRST_FLAGS_ADDR);
  assign hit_second = (bus_addr == SECOND_FLAGS_ADDR);

  // flag next state: set beats clear so no event is lost
  always_comb begin
    hold_vec = LEVEL_MASK & ~ev.raw;
    set_vec = ev.evt | hold_vec;
    clr_vec = SRC_ZERO;
    if (bus_wr && hit_first) begin
      // only ones clear; zeros leave the bit as it is
      clr_vec[FIRST_BASE +: REG_W] = bus_wdata;
    end else if (bus_wr && hit_second) begin
      clr_vec[SECOND_BASE +: REG_W] = bus_wdata;
    end
    // clear acts for the write cycle only, never held
    // the mask keeps the spare positions at zero whatever is written
    next_flags = ((flags & ~clr_vec) | set_vec) & (RISE_MASK | FALL_MASK);
  end

  // read data: a read never feeds back into the flags
  // limitation: data stands one cycle only, the core takes it then
  always_comb begin
    next_rdata = BUS_IDLE;
    if (bus_rd && hit_first) begin
      next_rdata = flags[FIRST_BASE +: REG_W];
    end else if (bus_rd && hit_second) begin
      next_rdata = flags[SECOND_BASE +: REG_W];
    end
  end

  // priority: scan upward so the highest index is kept last
  // a plain scan is cheap at sixteen positions, so no tree is built
  always_comb begin
    enables = {enable_second, enable_first};
    pending = flags & enables;
    next_irq = |pending;
    next_index = IDX_RESET;
    // second register sits in the upper half, so it always outranks
    for (int k = 0; k < SRC_W; k++) begin
      if (pending[k]) begin
        next_index = k[IDX_W-1:0];
      end
    end
  end

  // state registers
  // synchronous reset returns every register to its reset value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags <= {FLAGS_RESET, FLAGS_RESET};
      bus_rdata <= BUS_IDLE;
      irq_request <= 1'b0;
      vector_index <= IDX_RESET;
      pend_q <= SRC_ZERO;
    end else begin
      flags <= next_flags;
      bus_rdata <= next_rdata;
      irq_request <= next_irq;
      vector_index <= next_index;
      pend_q <= pending;
    end
  end

  // any source event shows in the flags one edge later
  set_event_a: assert property (@(posedge clk) disable iff (!nrst)
    (set_vec != SRC_ZERO) |=> ((flags & $past(set_vec)) == $past(set_vec)))
    else $error("event did not set its flag");

  // second low request keeps its flag up, a clearing write included
  level_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !second_external_low_request_n |=> flags[B_EXT_SECOND])
    else $error("second level flag dropped while request low");

  // first low request likewise
  first_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !first_external_low_request_n |=> flags[B_EXT_FIRST])
    else $error("first level flag dropped while request low");

  // a flag rises only with an edge or a held level behind it
  edge_only_a: assert property (@(posedge clk) disable iff (!nrst)
    (nrst && $past(nrst)) |-> ((flags & ~$past(flags) & ~$past(set_vec)) == SRC_ZERO))
    else $error("flag set without a cause");

  // reads leave every flag standing
  read_keeps_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_rd && !bus_wr) |=> ((~flags & $past(flags)) == SRC_ZERO))
    else $error("read disturbed a flag");

  // read data matches the second register when it is addressed
  read_data_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_rd && hit_second) |=> (bus_rdata == $past(flags[SECOND_BASE +: REG_W])))
    else $error("wrong read data");

  // the first register reads back the same way
  read_first_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_rd && hit_first) |=> (bus_rdata == $past(flags[FIRST_BASE +: REG_W])))
    else $error("wrong first register read data");

  // read data falls back to idle once no mapped read is taken
  idle_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (!bus_rd || (!hit_first && !hit_second)) |=> (bus_rdata == BUS_IDLE))
    else $error("read data not idle");

  // a one clears the bit when nothing sets it again
  clear_once_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_wr && hit_first && bus_wdata[0] && !set_vec[0]) |=> !flags[0] ##1
      (!$past(set_vec[0]) || flags[0]))
    else $error("write one clear misbehaved");

  // a one also clears a bit of the second register
  clear_second_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_wr && hit_second && bus_wdata[B_TIMER1 - SECOND_BASE] && !set_vec[B_TIMER1])
      |=> !flags[B_TIMER1])
    else $error("second register clear misbehaved");

  // zeros written leave set bits set
  zero_keeps_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_wr && hit_first) |=>
      ((($past(flags[FIRST_BASE +: REG_W]) & ~$past(bus_wdata)) &
        ~flags[FIRST_BASE +: REG_W]) == FLAGS_RESET))
    else $error("zero write cleared a flag");

  // a write to any other address clears nothing
  unmapped_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus_wr && !hit_first && !hit_second) |=> ((~flags & $past(flags)) == SRC_ZERO))
    else $error("stray write cleared a flag");

  // positions without a source never set
  spare_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (flags & ~(RISE_MASK | FALL_MASK)) == SRC_ZERO)
    else $error("flag without a source set");

  // pin falling edges land in first register bits 7, 6, 3, 2
  fall_map_a: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(port5_pin3) |=> flags[B_P5_PIN3_FALL]) and
    ($fell(port5_pin2) |=> flags[B_P5_PIN2_FALL]) and
    ($fell(port4_pin7) |=> flags[B_P4_PIN7_FALL]) and
    ($fell(port4_pin6) |=> flags[B_P4_PIN6_FALL]))
    else $error("pin falling edge missed its flag");

  // pin rising edges land in first register bits 5, 4, 1, 0
  rise_map_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(port5_pin1) |=> flags[B_P5_PIN1_RISE]) and
    ($rose(port5_pin0) |=> flags[B_P5_PIN0_RISE]) and
    ($rose(port4_pin5) |=> flags[B_P4_PIN5_RISE]) and
    ($rose(port4_pin4) |=> flags[B_P4_PIN4_RISE]))
    else $error("pin rising edge missed its flag");

  // timer events land in second register bits 5 and 4
  timer_map_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(timer2_edge) |=> flags[B_TIMER2]) and
    ($rose(timer1_edge) |=> flags[B_TIMER1]))
    else $error("timer event missed its flag");

  // second register pin sources: bit 3 falling, bit 2 rising
  upper_map_a: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(port5_pin7) |=> flags[B_P5_PIN7_FALL]) and
    ($rose(port5_pin6) |=> flags[B_P5_PIN6_RISE]))
    else $error("upper pin edge missed its flag");

  // the opposite transition leaves a clear flag clear
  opposite_edge_a: assert property (@(posedge clk) disable iff (!nrst)
    (($rose(port4_pin7) && !flags[B_P4_PIN7_FALL]) |=> !flags[B_P4_PIN7_FALL]) and
    (($fell(port4_pin4) && !flags[B_P4_PIN4_RISE]) |=> !flags[B_P4_PIN4_RISE]))
    else $error("opposite transition set a flag");

  // chosen vector is set and nothing above it is pending
  prio_high_a: assert property (@(posedge clk) disable iff (!nrst)
    irq_request |-> (pend_q[vector_index] && ((pend_q >> vector_index) >> 1) == SRC_ZERO))
    else $error("vector is not the highest pending");

  // any second bit beats the whole first register
  prio_upper_a: assert property (@(posedge clk) disable iff (!nrst)
    (pending[SECOND_BASE +: REG_W] != FLAGS_RESET) |=> vector_index[IDX_W-1])
    else $error("first register outranked the second");

  // with only first bits pending the index stays in the lower half
  prio_first_a: assert property (@(posedge clk) disable iff (!nrst)
    ((pending[SECOND_BASE +: REG_W] == FLAGS_RESET) && (pending != SRC_ZERO))
      |=> !vector_index[IDX_W-1])
    else $error("index outside the first register");

  // request follows pending flags one edge later
  irq_match_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (irq_request == ($past(pending) != SRC_ZERO)))
    else $error("request does not follow pending flags");

  // with nothing pending the index rests at its reset value
  index_rest_a: assert property (@(posedge clk) disable iff (!nrst)
    !irq_request |-> (vector_index == IDX_RESET))
    else $error("index moved without a request");

  // first edge after a reset shows the flags, the request and the index at their reset values
  reset_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> (flags == SRC_ZERO && !irq_request && vector_index == IDX_RESET))
    else $error("register not at reset value after reset");
endmodule

// ==== tb/ifp_core_model.sv ====
/*
  processor core stand-in: fetches the vector index whenever the flag unit
  raises its request. assumes the flag unit's clock and reset.
*/
`timescale 1ns/1ps
module ifp_core_model
  import ifp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request from the flag unit
  input wire logic irq_request,
  input wire logic [IDX_W-1:0] vector_index,
  // last vector fetched
  output logic [IDX_W-1:0] taken_vec
);
  logic [IDX_W-1:0] next_taken_vec; // fetch target
  // fetch only while requested, so a stale index is never taken
  always_comb begin
    next_taken_vec = taken_vec;
    if (irq_request) begin
      next_taken_vec = vector_index;
    end
  end
  // register the fetch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      taken_vec <= IDX_RESET;
    end else begin
      taken_vec <= next_taken_vec;
    end
  end
endmodule

// ==== tb/interrupt_flag_priority_unit_tb_top.sv ====
/*
  self-checking bench for the flag unit with a core model on its request.
  assumes sources synchronous to clk and the package bit positions.
*/
`timescale 1ns/1ps
module interrupt_flag_priority_unit_tb_top;
  import ifp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] enable_first = 8'hff;
  logic [7:0] enable_second = 8'hff;
  logic [SRC_W-1:0] src = PREV_RESET; // every source at its idle level
  logic [7:0] bus_rdata;
  logic irq_request;
  logic [3:0] vector_index;
  logic [3:0] taken_vec;
  int failures = 0;
  int num_checks = 0;
  // 200 MHz
  always #2.5 clk = ~clk;
  ifp_flag_unit dut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .enable_first(enable_first), .enable_second(enable_second),
    .port4_pin4(src[B_P4_PIN4_RISE]), .port4_pin5(src[B_P4_PIN5_RISE]),
    .port4_pin6(src[B_P4_PIN6_FALL]), .port4_pin7(src[B_P4_PIN7_FALL]),
    .port5_pin0(src[B_P5_PIN0_RISE]), .port5_pin1(src[B_P5_PIN1_RISE]),
    .port5_pin2(src[B_P5_PIN2_FALL]), .port5_pin3(src[B_P5_PIN3_FALL]),
    .port5_pin6(src[B_P5_PIN6_RISE]), .port5_pin7(src[B_P5_PIN7_FALL]),
    .timer1_edge(src[B_TIMER1]), .timer2_edge(src[B_TIMER2]),
    .first_external_low_request_n(src[B_EXT_FIRST]),
    .second_external_low_request_n(src[B_EXT_SECOND]),
    .irq_request(irq_request), .vector_index(vector_index));
  ifp_core_model core (.clk(clk), .nrst(nrst), .irq_request(irq_request),
    .vector_index(vector_index), .taken_vec(taken_vec));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one read strobe, data looked at in the cycle it stands
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk({8'h00, bus_rdata}, {8'h00, exp}, "read data");
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rdall(input logic [15:0] exp);
    rd(FIRST_FLAGS_ADDR, exp[7:0]);
    rd(SECOND_FLAGS_ADDR, exp[15:8]);
  endtask
  task automatic wr_both(input logic [15:0] d);
    wr(FIRST_FLAGS_ADDR, d[7:0]);
    wr(SECOND_FLAGS_ADDR, d[15:8]);
  endtask
  // toggle one source, then let the flag and the request settle
  task automatic flip(input int i);
    @(posedge clk);
    src[i] <= ~src[i];
    tick(3);
    #1;
  endtask
  task automatic test_reset();
    rdall(16'h0000);
    rd(16'h0010, BUS_IDLE); // unmapped address
    chk({15'h0000, irq_request}, 16'h0000, "request after reset");
    $display("reset test done");
  endtask
  // every edge source: set, zero write, clear, opposite edge, set again
  task automatic test_edges();
    logic [15:0] m;
    for (int i = 0; i < SRC_W; i++) begin
      m = 16'h0001 << i;
      if (((RISE_MASK | FALL_MASK) & ~LEVEL_MASK & m) != 16'h0000) begin
        flip(i);
        rdall(m);
        wr_both(~m);
        rdall(m);
        wr_both(m);
        rdall(16'h0000);
        flip(i);
        rdall(16'h0000);
        flip(i);
        rdall(m);
        flip(i);
        wr_both(m);
      end
    end
    $display("edge test done");
  endtask
  // low requests hold their flag against a clear
  task automatic test_levels();
    logic [15:0] m;
    for (int i = B_EXT_FIRST; i <= B_EXT_SECOND; i++) begin
      m = 16'h0001 << i;
      flip(i);
      rdall(m);
      wr_both(m);
      rdall(m);
      flip(i);
      wr_both(m);
      rdall(16'h0000);
    end
    $display("level test done");
  endtask
  task automatic test_priority();
    flip(B_P4_PIN4_RISE);
    flip(B_P5_PIN7_FALL);
    chk({12'h000, vector_index}, 16'd11, "second above first");
    chk({12'h000, taken_vec}, 16'd11, "core fetch");
    flip(B_P4_PIN4_RISE);
    flip(B_P5_PIN7_FALL);
    wr_both(16'hffff);
    tick(2);
    chk({15'h0000, irq_request}, 16'h0000, "request drops");
    flip(B_P4_PIN7_FALL);
    flip(B_P4_PIN6_FALL);
    flip(B_P5_PIN6_RISE);
    chk({12'h000, vector_index}, 16'd10, "lowest second bit wins");
    enable_second <= 8'h00;
    tick(3);
    chk({12'h000, vector_index}, 16'd3, "highest enabled");
    enable_first <= 8'h04;
    tick(3);
    chk({12'h000, vector_index}, 16'd2, "masked bit skipped");
    enable_first <= 8'h00;
    tick(3);
    chk({15'h0000, irq_request}, 16'h0000, "all masked");
    enable_first <= 8'hff;
    enable_second <= 8'hff;
    flip(B_P4_PIN7_FALL);
    flip(B_P4_PIN6_FALL);
    flip(B_P5_PIN6_RISE);
    wr_both(16'hffff);
    $display("priority test done");
  endtask
  // stray write, reset in mid-run, then a one-sample pulse
  task automatic test_midrun();
    flip(B_P4_PIN7_FALL);
    flip(B_P4_PIN7_FALL);
    wr(16'h0010, 8'hff);
    rdall(16'h0008);
    @(posedge clk);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    #1 chk({15'h0000, irq_request}, 16'h0000, "request after mid reset");
    chk({12'h000, vector_index}, 16'h0000, "index after mid reset");
    rdall(16'h0000);
    @(posedge clk);
    src[B_P4_PIN6_FALL] <= 1'b0;
    @(posedge clk);
    src[B_P4_PIN6_FALL] <= 1'b1;
    tick(2);
    rdall(16'h0004);
    wr_both(16'hffff);
    rdall(16'h0000);
    $display("mid-run reset test done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    tick(20000);
    failures++;
    $display("FAIL t=%0t run timed out", $time);
    summarize();
  end
  initial begin
    tick(16);
    nrst <= 1'b1;
    test_reset();
    test_edges();
    test_levels();
    test_priority();
    test_midrun();
    summarize();
  end
endmodule
